// File: hdl/dsp_host_end.sv
`timescale 1ns/1ps

module dsp_host_end
    import dsp_pkg::*;
(
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst_b,
    // link
    dsp_link_if.host           link,
    // software port
    input  wire dsp_pkg::dsp_sw_addr_t sw_addr,
    input  wire dsp_pkg::dsp_word_t    sw_wdata,
    input  wire logic          sw_wr,
    input  wire logic          sw_rd,
    output dsp_pkg::dsp_word_t sw_rdata
);
    import dsp_pkg::*;

    typedef enum logic [4:0] {
        H_IDLE = 5'b00001,
        H_LOW  = 5'b00010,
        H_HIGH = 5'b00100,
        H_END  = 5'b01000,
        H_RST  = 5'b10000
    } dsp_hstate_t;

    localparam logic [7:0] HALF_CNT = 8'(SCLK_HALF_CYC - 1);
    localparam logic [7:0] RST_CNT  = 8'(PORT_RST_CYC - 1);

    dsp_hstate_t state_reg, state_next;
    logic [7:0]  div_reg, div_next;
    logic [5:0]  bit_reg, bit_next;
    logic [7:0]  instr_reg, instr_next;
    dsp_word_t   tx_reg, tx_next, rx_reg, rx_next, rdata_reg, rdata_next;
    logic [1:0]  cfg_reg, cfg_next;
    logic        sclk_reg, sclk_next, cs_n_reg, cs_n_next, prst_reg, prst_next;
    logic        so_reg, so_next, oe_b_reg, oe_b_next;
    logic [1:0]  line_sync;
    logic        rx_bit;
    logic [63:0] frame;
    logic [5:0]  total;
    logic [5:0]  sel;
    logic [5:0]  nxt;
    logic [5:0]  nsel;
    logic        start;

    // ----------------------------------------------------------------
    // returning data line
    // ----------------------------------------------------------------
    dsp_sync2 #(.W(2)) u_sync (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .d       ({link.sdo, link.sdio}),
        .q       (line_sync)
    );

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        div_next   = div_reg;
        bit_next   = bit_reg;
        instr_next = instr_reg;
        tx_next    = tx_reg;
        rx_next    = rx_reg;
        cfg_next   = cfg_reg;
        sclk_next  = sclk_reg;
        cs_n_next  = cs_n_reg;
        prst_next  = prst_reg;
        so_next    = so_reg;
        oe_b_next  = oe_b_reg;
        rdata_next = '0;
        frame      = {24'h000000, tx_reg, instr_reg};
        total      = {3'(instr_reg[CNT_HI:CNT_LO]) + 3'd2, 3'b000};
        rx_bit     = cfg_reg[CFG_3WIRE_BIT] ? line_sync[0] : line_sync[1];
        // bit order inside each byte follows the configured order
        sel        = {bit_reg[5:3], cfg_reg[CFG_LSB_BIT] ? bit_reg[2:0] : ~bit_reg[2:0]};
        nxt        = 6'(bit_reg + 6'd1);
        nsel       = {nxt[5:3], cfg_reg[CFG_LSB_BIT] ? nxt[2:0] : ~nxt[2:0]};
        start      = 1'b0;
        if (sw_rd) begin
            unique case (sw_addr)
                HREG_INSTR:  rdata_next = {24'h000000, instr_reg};
                HREG_TXDATA: rdata_next = tx_reg;
                HREG_RXDATA: rdata_next = rx_reg;
                HREG_STATUS: rdata_next = {31'h00000000, state_reg != H_IDLE};
                HREG_CFG:    rdata_next = {30'h00000000, cfg_reg};
                default:     rdata_next = '0;
            endcase
        end
        // settings and payload only change while the link is quiet
        if (sw_wr && state_reg == H_IDLE) begin
            if (sw_addr == HREG_TXDATA) tx_next = sw_wdata;
            if (sw_addr == HREG_CFG) cfg_next = sw_wdata[1:0];
            if (sw_addr == HREG_INSTR) begin
                instr_next = sw_wdata[7:0];
                start      = 1'b1;
            end
        end
        unique case (state_reg)
            H_IDLE: begin
                if (start) begin
                    state_next = H_LOW;
                    cs_n_next  = 1'b0;
                    div_next   = '0;
                    bit_next   = '0;
                    so_next    = sw_wdata[cfg_reg[CFG_LSB_BIT] ? 0 : 7];
                    oe_b_next  = 1'b0;
                end
            end
            H_LOW: begin
                div_next = 8'(div_reg + 8'd1);
                if (div_reg == HALF_CNT) begin
                    div_next   = '0;
                    sclk_next  = 1'b1;
                    state_next = H_HIGH;
                    if (instr_reg[DIR_BIT] && bit_reg[5:3] != 3'd0) begin
                        rx_next[{2'(bit_reg[5:3] - 3'd1), sel[2:0]}] = rx_bit;
                    end
                end
            end
            H_HIGH: begin
                div_next = 8'(div_reg + 8'd1);
                if (div_reg == HALF_CNT) begin
                    div_next  = '0;
                    sclk_next = 1'b0;
                    bit_next  = nxt;
                    so_next   = frame[nsel];
                    // hand the line over once the instruction is out
                    oe_b_next = instr_reg[DIR_BIT] && nxt[5:3] != 3'd0;
                    state_next = (nxt == total) ? H_END : H_LOW;
                end
            end
            H_END: begin
                div_next  = 8'(div_reg + 8'd1);
                oe_b_next = 1'b1;
                if (div_reg == HALF_CNT) begin
                    cs_n_next  = 1'b1;
                    state_next = H_IDLE;
                end
            end
            H_RST: begin
                div_next = 8'(div_reg + 8'd1);
                if (div_reg == RST_CNT) begin
                    prst_next  = 1'b0;
                    state_next = H_IDLE;
                end
            end
        endcase
        // a port reset is taken at any time and cuts a running frame short
        if (sw_wr && sw_addr == HREG_CFG && sw_wdata[CFG_PRST_BIT]) begin
            state_next = H_RST;
            prst_next  = 1'b1;
            div_next   = '0;
            cs_n_next  = 1'b1;
            sclk_next  = 1'b0;
            oe_b_next  = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= H_IDLE;
            div_reg   <= '0;
            bit_reg   <= '0;
            instr_reg <= '0;
            tx_reg    <= '0;
            rx_reg    <= '0;
            rdata_reg <= '0;
            cfg_reg   <= '0;
            sclk_reg  <= 1'b0;
            cs_n_reg  <= 1'b1;
            prst_reg  <= 1'b0;
            so_reg    <= 1'b0;
            oe_b_reg  <= 1'b1;
        end else begin
            state_reg <= state_next;
            div_reg   <= div_next;
            bit_reg   <= bit_next;
            instr_reg <= instr_next;
            tx_reg    <= tx_next;
            rx_reg    <= rx_next;
            rdata_reg <= rdata_next;
            cfg_reg   <= cfg_next;
            sclk_reg  <= sclk_next;
            cs_n_reg  <= cs_n_next;
            prst_reg  <= prst_next;
            so_reg    <= so_next;
            oe_b_reg  <= oe_b_next;
        end
    end

    assign link.sclk          = sclk_reg;
    assign link.chip_select_n = cs_n_reg;
    assign link.port_reset    = prst_reg;
    assign link.sdio_h_o      = so_reg;
    assign link.sdio_h_oe_b   = oe_b_reg;
    assign sw_rdata           = rdata_reg;
endmodule

// File: hdl/dsp_pkg.sv
package dsp_pkg;

    // ----------------------------------------------------------------
    // instruction byte layout
    // ----------------------------------------------------------------
    localparam int DIR_BIT  = 7;
    localparam int CNT_HI   = 6;
    localparam int CNT_LO   = 5;
    localparam int ADDR_MSB = 4;

    // ----------------------------------------------------------------
    // device register file
    // ----------------------------------------------------------------
    localparam int        NUM_REGS        = 32;
    localparam logic [4:0] CTRL_ADDR      = 5'h00;
    localparam int        CTRL_3WIRE_BIT  = 7;
    localparam int        CTRL_ORDER_BIT  = 6;
    localparam logic [7:0] CTRL_RESET     = 8'h80;
    localparam logic [7:0] REG_RESET      = 8'h00;

    typedef logic [4:0] dsp_addr_t;
    typedef logic [7:0] dsp_byte_t;

    // ----------------------------------------------------------------
    // host timing
    // ----------------------------------------------------------------
    localparam int REF_CLK_MHZ  = 100;
    localparam int SCLK_MAX_MHZ = 20;
    // least half period, rounded up so the link never exceeds its maximum
    localparam int SCLK_HALF_CYC = (REF_CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
    localparam int PORT_RST_NS   = 100;
    localparam int PORT_RST_CYC  = (PORT_RST_NS * REF_CLK_MHZ + 999) / 1000;

    // ----------------------------------------------------------------
    // host software registers
    // ----------------------------------------------------------------
    localparam logic [2:0] HREG_INSTR  = 3'h0;
    localparam logic [2:0] HREG_TXDATA = 3'h1;
    localparam logic [2:0] HREG_RXDATA = 3'h2;
    localparam logic [2:0] HREG_STATUS = 3'h3;
    localparam logic [2:0] HREG_CFG    = 3'h4;
    localparam int         CFG_LSB_BIT   = 0;
    localparam int         CFG_3WIRE_BIT = 1;
    localparam int         CFG_PRST_BIT  = 2;
    localparam int         STAT_BUSY_BIT = 0;

    typedef logic [2:0]  dsp_sw_addr_t;
    typedef logic [31:0] dsp_word_t;

endpackage

// File: hdl/dsp_link_if.sv
`timescale 1ns/1ps

interface dsp_link_if;
    logic sclk;
    logic chip_select_n;
    logic port_reset;
    logic sdio_h_o;
    logic sdio_h_oe_b;
    logic sdio_d_o;
    logic sdio_d_oe_b;
    logic sdo;
    // resolved data line; an undriven line floats high through a pull-up
    logic sdio;

    assign sdio = !sdio_h_oe_b ? sdio_h_o : (!sdio_d_oe_b ? sdio_d_o : 1'b1);

    modport host (
        output sclk,
        output chip_select_n,
        output port_reset,
        output sdio_h_o,
        output sdio_h_oe_b,
        input  sdio,
        input  sdo
    );

    modport dev (
        input  sclk,
        input  chip_select_n,
        input  port_reset,
        input  sdio,
        output sdio_d_o,
        output sdio_d_oe_b,
        output sdo
    );
endinterface

// File: hdl/dsp_sync2.sv
`timescale 1ns/1ps

module dsp_sync2 #(
    parameter int W = 2
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst_b,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // first stage feeds only the second
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule

// File: hdl/dsp_dev_end.sv
`timescale 1ns/1ps

module dsp_dev_end
    import dsp_pkg::*;
(
    // link
    dsp_link_if.dev           link,
    // power-on reset
    input  wire logic         rst_b,
    // configuration view
    output dsp_pkg::dsp_byte_t ctrl_value,
    // write notification, link clock domain
    output logic              wr_pulse,
    output dsp_pkg::dsp_addr_t wr_addr,
    output dsp_pkg::dsp_byte_t wr_data
);
    import dsp_pkg::*;

    typedef enum logic [3:0] {
        ST_INSTR = 4'b0001,
        ST_WRITE = 4'b0010,
        ST_READ  = 4'b0100,
        ST_DONE  = 4'b1000
    } dsp_dstate_t;

    dsp_dstate_t state_reg, state_next;
    logic [2:0]  bit_reg, bit_next;
    dsp_byte_t   shift_reg, shift_next;
    dsp_addr_t   addr_reg, addr_next;
    logic [1:0]  left_reg, left_next;
    logic        rd_flag_reg, rd_flag_next;
    logic        wr_pulse_reg, wr_pulse_next;
    dsp_addr_t   wr_addr_reg, wr_addr_next;
    dsp_byte_t   wr_data_reg, wr_data_next;
    dsp_byte_t   regs_reg [NUM_REGS];
    dsp_byte_t   regs_next [NUM_REGS];
    logic        so_reg, so_next;
    logic        oe_b_reg, oe_b_next;
    logic        sdo_reg, sdo_next;
    logic        seq_rst_b;
    logic        lsb_first;
    logic        three_wire;
    logic        wr_en;
    dsp_byte_t   shifted;
    dsp_byte_t   rd_byte;
    logic [2:0]  rd_idx;

    // ----------------------------------------------------------------
    // sequencer reset
    // ----------------------------------------------------------------
    // the serial clock may be stopped during a port reset or deselect,
    // so both act without it; the register file only sees rst_b
    assign seq_rst_b  = rst_b && !link.port_reset && !link.chip_select_n;
    assign lsb_first  = regs_reg[CTRL_ADDR][CTRL_ORDER_BIT];
    assign three_wire = regs_reg[CTRL_ADDR][CTRL_3WIRE_BIT];

    // ----------------------------------------------------------------
    // rising edge: instruction and data capture
    // ----------------------------------------------------------------
    always_comb begin
        state_next    = state_reg;
        bit_next      = 3'(bit_reg + 3'd1);
        addr_next     = addr_reg;
        left_next     = left_reg;
        rd_flag_next  = rd_flag_reg;
        wr_pulse_next = 1'b0;
        wr_addr_next  = wr_addr_reg;
        wr_data_next  = wr_data_reg;
        wr_en         = 1'b0;
        // shift direction tracks the bit order in force right now
        shifted       = lsb_first ? {link.sdio, shift_reg[7:1]}
                                  : {shift_reg[6:0], link.sdio};
        shift_next    = shifted;
        unique case (state_reg)
            ST_INSTR: begin
                if (bit_reg == 3'd7) begin
                    addr_next = shifted[ADDR_MSB:0];
                    left_next = shifted[CNT_HI:CNT_LO];
                    if (shifted[DIR_BIT]) begin
                        state_next   = ST_READ;
                        rd_flag_next = 1'b1;
                    end else begin
                        state_next = ST_WRITE;
                    end
                end
            end
            ST_WRITE, ST_READ: begin
                if (bit_reg == 3'd7) begin
                    if (state_reg == ST_WRITE) begin
                        // a byte lands only when complete, so a cut-off byte is lost
                        wr_en         = 1'b1;
                        wr_pulse_next = 1'b1;
                        wr_addr_next  = addr_reg;
                        wr_data_next  = shifted;
                    end
                    if (left_reg == 2'd0) begin
                        state_next = ST_DONE;
                    end else begin
                        left_next = 2'(left_reg - 2'd1);
                        // no saturation: a run past the end wraps around
                        addr_next = lsb_first ? 5'(addr_reg + 5'd1)
                                              : 5'(addr_reg - 5'd1);
                    end
                end
            end
            ST_DONE: begin
                bit_next = bit_reg;
            end
        endcase
    end

    always_ff @(posedge link.sclk or negedge seq_rst_b) begin
        if (!seq_rst_b) begin
            state_reg   <= ST_INSTR;
            bit_reg     <= '0;
            shift_reg   <= '0;
            addr_reg    <= '0;
            left_reg    <= '0;
            rd_flag_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            bit_reg     <= bit_next;
            shift_reg   <= shift_next;
            addr_reg    <= addr_next;
            left_reg    <= left_next;
            rd_flag_reg <= rd_flag_next;
        end
    end

    // ----------------------------------------------------------------
    // register file and write notification
    // ----------------------------------------------------------------
    always_comb begin
        regs_next = regs_reg;
        if (wr_en) begin
            regs_next[addr_reg] = shifted;
        end
    end

    always_ff @(posedge link.sclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_reg[i] <= (i == int'(CTRL_ADDR)) ? CTRL_RESET : REG_RESET;
            end
            wr_pulse_reg <= 1'b0;
            wr_addr_reg  <= '0;
            wr_data_reg  <= '0;
        end else begin
            regs_reg     <= regs_next;
            wr_pulse_reg <= wr_pulse_next;
            wr_addr_reg  <= wr_addr_next;
            wr_data_reg  <= wr_data_next;
        end
    end

    // ----------------------------------------------------------------
    // falling edge: read data out
    // ----------------------------------------------------------------
    always_comb begin
        rd_byte   = regs_reg[addr_reg];
        rd_idx    = lsb_first ? bit_reg : ~bit_reg;
        so_next   = 1'b0;
        sdo_next  = 1'b0;
        oe_b_next = 1'b1;
        if (state_reg == ST_READ) begin
            if (three_wire) begin
                so_next = rd_byte[rd_idx];
            end else begin
                sdo_next = rd_byte[rd_idx];
            end
        end
        // keep driving to the end of the cycle; only deselect, a port reset or rst_b lets go
        if (rd_flag_reg && three_wire) begin
            oe_b_next = 1'b0;
        end
    end

    always_ff @(negedge link.sclk or negedge seq_rst_b) begin
        if (!seq_rst_b) begin
            so_reg   <= 1'b0;
            sdo_reg  <= 1'b0;
            oe_b_reg <= 1'b1;
        end else begin
            so_reg   <= so_next;
            sdo_reg  <= sdo_next;
            oe_b_reg <= oe_b_next;
        end
    end

    assign link.sdio_d_o    = so_reg;
    assign link.sdio_d_oe_b = oe_b_reg;
    assign link.sdo         = sdo_reg;
    assign ctrl_value       = regs_reg[CTRL_ADDR];
    assign wr_pulse         = wr_pulse_reg;
    assign wr_addr          = wr_addr_reg;
    assign wr_data          = wr_data_reg;
endmodule

// File: verif/dsp_link_sva.sv
`timescale 1ns/1ps

module dsp_link_sva (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // link
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic port_reset,
    input wire logic sdio_h_o,
    input wire logic sdio_h_oe_b,
    input wire logic sdio_d_o,
    input wire logic sdio_d_oe_b,
    input wire logic sdo,
    input wire logic sdio
);
    // ----------------------------------------------------------------
    // rise counter per frame
    // ----------------------------------------------------------------
    logic       sclk_reg;
    logic       sclk_next;
    logic [5:0] rise_reg;
    logic [5:0] rise_next;

    always_comb begin
        sclk_next = sclk;
        rise_next = rise_reg;
        if (chip_select_n) begin
            rise_next = '0;
        end else if (sclk && !sclk_reg) begin
            rise_next = rise_reg + 6'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_reg <= 1'b0;
            rise_reg <= '0;
        end else begin
            sclk_reg <= sclk_next;
            rise_reg <= rise_next;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    sequence s_high_half;
        sclk [*3];
    endsequence
    sequence s_low_half;
        (!sclk) [*3];
    endsequence

    property p_idle_release;
        chip_select_n && $past(chip_select_n) |-> sdio_d_oe_b && !sdo;
    endproperty
    property p_port_rst;
        port_reset |-> sdio_d_oe_b && !sdo;
    endproperty
    property p_no_clash;
        !sdio_h_oe_b |-> sdio_d_oe_b;
    endproperty
    property p_drive_late;
        !sdio_d_oe_b |-> rise_reg >= 6'd8;
    endproperty
    property p_sclk_idle;
        chip_select_n |-> !sclk;
    endproperty
    property p_high_half;
        $rose(sclk) |-> s_high_half ##1 !sclk;
    endproperty
    property p_low_half;
        $fell(sclk) && !chip_select_n |-> s_low_half;
    endproperty
    property p_frame_len;
        $rose(chip_select_n) && !port_reset |-> rise_reg inside {6'd16, 6'd24, 6'd32, 6'd40};
    endproperty
    property p_instr_host;
        !chip_select_n && rise_reg < 6'd8 |-> !sdio_h_oe_b;
    endproperty
    property p_host_bit;
        $changed(sdio_h_o) && !sdio_h_oe_b |-> !sclk;
    endproperty
    property p_dev_fall;
        $changed(sdio_d_o) && !chip_select_n && !port_reset |-> $fell(sclk);
    endproperty

    a_idle_release: assert property (p_idle_release) else $error("line not released");
    a_port_rst: assert property (p_port_rst) else $error("port reset ignored");
    a_no_clash: assert property (p_no_clash) else $error("both ends drive");
    a_drive_late: assert property (p_drive_late) else $error("device drove early");
    a_sclk_idle: assert property (p_sclk_idle) else $error("clock outside frame");
    a_high_half: assert property (p_high_half) else $error("high half wrong");
    a_low_half: assert property (p_low_half) else $error("low half short");
    a_frame_len: assert property (p_frame_len) else $error("bad frame length");
    a_instr_host: assert property (p_instr_host) else $error("host not driving");
    a_host_bit: assert property (p_host_bit) else $error("host bit moved high");
    a_dev_fall: assert property (p_dev_fall) else $error("read bit off fall");
endmodule

// File: verif/dac_serial_control_port_tb_top.sv
`timescale 1ns/1ps

module dac_serial_control_port_tb_top;
    import dsp_pkg::*;

    logic         ref_clk = 1'b0;
    logic         rst_b = 1'b1;
    dsp_sw_addr_t sw_addr = '0;
    dsp_word_t    sw_wdata = '0;
    logic         sw_wr = 1'b0;
    logic         sw_rd = 1'b0;
    dsp_word_t    sw_rdata;
    dsp_byte_t    ctrl_value;
    dsp_byte_t    wr_data;
    dsp_addr_t    wr_addr;
    logic         wr_pulse;
    int           errors = 0;
    int           comparisons = 0;
    dsp_addr_t    log_a[$];
    dsp_byte_t    log_d[$];
    dsp_word_t    r;

    always #5 ref_clk = ~ref_clk;

    dsp_link_if link();
    dsp_host_end dsp_host_end_i (.ref_clk(ref_clk), .rst_b(rst_b), .link(link),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata));
    dsp_dev_end dsp_dev_end_i (.link(link), .rst_b(rst_b), .ctrl_value(ctrl_value),
        .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data));
    dsp_link_sva dsp_link_sva_i (.ref_clk(ref_clk), .rst_b(rst_b), .sclk(link.sclk),
        .chip_select_n(link.chip_select_n), .port_reset(link.port_reset),
        .sdio_h_o(link.sdio_h_o), .sdio_h_oe_b(link.sdio_h_oe_b), .sdio_d_o(link.sdio_d_o),
        .sdio_d_oe_b(link.sdio_d_oe_b), .sdo(link.sdo), .sdio(link.sdio));

    // the pulse spans one rise interval, so the fall always sees it, even after the last byte
    always @(negedge link.sclk) begin
        if (wr_pulse === 1'b1) begin
            log_a.push_back(wr_addr);
            log_d.push_back(wr_data);
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input dsp_sw_addr_t a, input dsp_word_t d);
        @(posedge ref_clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge ref_clk);
        sw_wr <= 1'b0;
    endtask

    task automatic rd(input dsp_sw_addr_t a, output dsp_word_t d);
        @(posedge ref_clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge ref_clk);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask

    task automatic frame(input dsp_byte_t ins, input dsp_word_t tx);
        dsp_word_t s;
        wr(HREG_TXDATA, tx);
        wr(HREG_INSTR, {24'h0, ins});
        for (int i = 0; i < 400; i++) begin
            rd(HREG_STATUS, s);
            if (s[STAT_BUSY_BIT] === 1'b0) break;
        end
        check(s[STAT_BUSY_BIT], 1'b0);
    endtask

    task automatic check_log(input dsp_addr_t a0, input int n, input int step, input dsp_word_t d);
        check(log_a.size(), n);
        for (int k = 0; k < n && k < log_a.size(); k++) begin
            check(log_a[k], dsp_addr_t'(a0 + step * k));
            check(log_d[k], d[8*k+:8]);
        end
        log_a.delete();
        log_d.delete();
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        check(ctrl_value, 8'h80);
        check(link.sdio_d_oe_b, 1'b1);
        $display("test reset done");
    endtask

    task automatic t_write_msb();
        for (int n = 0; n < 4; n++) begin
            frame({1'b0, n[1:0], 5'h1a}, 32'h44332211);
            check_log(5'h1a, n + 1, -1, 32'h44332211);
        end
        $display("test write_msb done");
    endtask

    task automatic t_read_msb();
        frame(8'hfa, 32'h0);
        rd(HREG_RXDATA, r);
        check(r, 32'h44332211);
        check(log_a.size(), 0);
        $display("test read_msb done");
    endtask

    task automatic t_lsb();
        frame(8'h00, 32'hc0);
        check(ctrl_value, 8'hc0);
        check_log(5'h00, 1, 0, 32'hc0);
        wr(HREG_CFG, 32'h3);
        frame(8'h45, 32'h00ccbbaa);
        check_log(5'h05, 3, 1, 32'h00ccbbaa);
        frame(8'hc5, 32'h0);
        rd(HREG_RXDATA, r);
        check(r & 32'h00ffffff, 32'h00ccbbaa);
        frame(8'h00, 32'h80);
        wr(HREG_CFG, 32'h2);
        check(ctrl_value, 8'h80);
        log_a.delete();
        log_d.delete();
        $display("test lsb done");
    endtask

    task automatic t_four_wire();
        frame(8'h00, 32'h0);
        wr(HREG_CFG, 32'h0);
        frame(8'h9a, 32'h0);
        rd(HREG_RXDATA, r);
        check(r & 32'hff, 32'h11);
        frame(8'h00, 32'h80);
        wr(HREG_CFG, 32'h2);
        log_a.delete();
        log_d.delete();
        $display("test four_wire done");
    endtask

    task automatic t_port_reset();
        // cut a one-byte write to 0x1c at the fall after its fourth data bit
        wr(HREG_TXDATA, 32'ha5);
        wr(HREG_INSTR, 32'h1c);
        repeat (70) @(posedge ref_clk);
        wr(HREG_CFG, 32'h6);
        repeat (PORT_RST_CYC + 4) @(posedge ref_clk);
        check(link.sdio_d_oe_b, 1'b1);
        check(ctrl_value, 8'h80);
        check(log_a.size(), 0);
        frame(8'h1b, 32'h5c);
        check_log(5'h1b, 1, 0, 32'h5c);
        frame(8'h9c, 32'h0);
        rd(HREG_RXDATA, r);
        check(r & 32'hff, 32'h00);
        $display("test port_reset done");
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        give_verdict();
    end

    initial begin
        rst_b <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_reset();
        wr(HREG_CFG, 32'h2);
        t_write_msb();
        t_read_msb();
        t_lsb();
        t_four_wire();
        t_port_reset();
        give_verdict();
    end
endmodule
